// >>> logic/pwm_pkg.sv
`default_nettype none
package pwm_pkg;
    // ----------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_CFG = 8'hD1;
    localparam logic [7:0] IDX_CTRL = 8'hD2;
    localparam logic [7:0] IDX_PRD = 8'hD3;
    localparam logic [7:0] IDX_LOW = 8'hD4;
    localparam logic [7:0] IDX_DTY0 = 8'hD5;
    localparam logic [7:0] IDX_DTY1 = 8'hD6;
    localparam logic [7:0] IDX_DTY2 = 8'hD7;
    localparam logic [7:0] IDX_MODEB = 8'hDC;
    localparam logic [7:0] IDX_DEAD = 8'hDD;
    localparam logic [7:0] IDX_CH4 = 8'hDE;
    localparam logic [7:0] IDX_CH5 = 8'hDF;
    localparam logic [7:0] IDX_ISTAT = 8'hE0;
    localparam logic [7:0] IDX_IMASK = 8'hE1;
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int EN_BIT = 7;
    localparam int FLAG_BIT = 6;
    localparam int MODE_BIT = 7;
    localparam int CKS_LSB = 6;
    localparam int PRDLO_LSB = 6;
    localparam int PDF_LSB = 4;
    localparam int PDR_LSB = 0;
    localparam logic [7:0] MODEB_MASK = 8'hBF;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [23:0] PAD_ZERO = 24'h000000;
    // Prescaler terminal counts for fosc/1, /2, /8, /32
    localparam logic [4:0] LIM_DIV1 = 5'h00;
    localparam logic [4:0] LIM_DIV2 = 5'h01;
    localparam logic [4:0] LIM_DIV8 = 5'h07;
    localparam logic [4:0] LIM_DIV32 = 5'h1F;
    localparam logic [4:0] PRE_ONE = 5'h01;
    localparam logic [9:0] CNT_ONE = 10'h001;
    localparam logic [3:0] DT_ONE = 4'h1;
    // ----------------------------------------------------------------
    // Whole block state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic en;
        logic [1:0] cks;
        logic [5:0] inv;
        logic [7:0] prdHigh;
        logic [7:0] lowBits;
        logic [2:0][7:0] dutyHigh;
        logic [7:0] modeB;
        logic [7:0] deadCfg;
        logic [7:0] ch4Duty;
        logic [7:0] ch5Duty;
        logic [2:0][9:0] actDuty;
        logic [9:0] actPrd;
        logic [4:0] pre;
        logic [9:0] cnt;
        logic [5:0][3:0] dc;
        logic [5:0] o;
        logic [5:0] out;
        logic flag;
        logic mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;
endpackage : pwm_pkg
`default_nettype wire

// >>> logic/complementary_pwm_dead_time.sv
// Functional notes
// - With the mode bit set, outputs pair 0/3, 1/4, 2/5 and each pair uses duty 0, 1 or 2.
// - In complementary mode channel 4/5 duty registers are ignored and channel 3's is the dead-time register.
// - Dead time keeps the two outputs of a pair from ever being active together.
// - Each 10-bit duty is the 8-bit high byte plus 2 shared low bits; active width is that many counts.
// - The shared low register holds period bits in 7-6 and duty 2, 1, 0 low bits in 5-4, 3-2, 1-0.
// - Secondary outputs 3-5 rise after a falling-edge dead time of bits 7-4 in oscillator clocks.
// - Primary outputs 0-2 rise after a rising-edge dead time of bits 3-0 in oscillator clocks.
// - A new duty takes effect only from the next period.
// - A new period takes effect only from the next period.
// - Each output invert bit at 1 inverts that channel's waveform.
// - The counter wraps to zero after reaching the period value, giving period plus one counts.
// - The prescale code selects a count clock of fosc divided by 1, 2, 8 or 32.
// - Every wrap sets the shared overflow flag, which raises the interrupt when enabled.
// - Clearing the module enable stops the unit and zeroes the counter.
//
// Register access over APB was chosen for this implementation.
`default_nettype none
module complementary_pwm_dead_time #(
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic [5:0] pwmOut,
    output logic irq
);
    pwm_pkg::state_t q_r;
    pwm_pkg::state_t q_nxt;
    logic access;
    logic wrEn;
    logic mapped;
    logic tick;
    logic wrap;
    logic compMode;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [5:0] raw;
    logic [5:0][3:0] dly;
    logic [2:0][9:0] dutyReg;

    function automatic logic [4:0] preLimit(input logic [1:0] cks);
        case (cks)
            2'h0: preLimit = pwm_pkg::LIM_DIV1;
            2'h1: preLimit = pwm_pkg::LIM_DIV2;
            2'h2: preLimit = pwm_pkg::LIM_DIV8;
            default: preLimit = pwm_pkg::LIM_DIV32;
        endcase
    endfunction : preLimit

    assign pready = q_r.pready;
    assign prdata = q_r.prdata;
    assign pslverr = q_r.pslverr;
    assign pwmOut = q_r.out;
    assign irq = q_r.irq;

    // ----------------------------------------------------------------
    // Register decode and readback
    // ----------------------------------------------------------------
    always_comb
    begin
        idx = paddr[9:2];
        mapped = 1'b1;
        rbyte = pwm_pkg::RST_BYTE;
        case (idx)
            pwm_pkg::IDX_CFG: rbyte = {q_r.cks, q_r.inv};
            pwm_pkg::IDX_CTRL:
            begin
                rbyte[pwm_pkg::EN_BIT] = q_r.en;
                rbyte[pwm_pkg::FLAG_BIT] = q_r.flag;
            end
            pwm_pkg::IDX_PRD: rbyte = q_r.prdHigh;
            pwm_pkg::IDX_LOW: rbyte = q_r.lowBits;
            pwm_pkg::IDX_DTY0: rbyte = q_r.dutyHigh[0];
            pwm_pkg::IDX_DTY1: rbyte = q_r.dutyHigh[1];
            pwm_pkg::IDX_DTY2: rbyte = q_r.dutyHigh[2];
            pwm_pkg::IDX_MODEB: rbyte = q_r.modeB;
            pwm_pkg::IDX_DEAD: rbyte = q_r.deadCfg;
            pwm_pkg::IDX_CH4: rbyte = q_r.ch4Duty;
            pwm_pkg::IDX_CH5: rbyte = q_r.ch5Duty;
            pwm_pkg::IDX_ISTAT: rbyte = {7'h00, q_r.flag};
            pwm_pkg::IDX_IMASK: rbyte = {7'h00, q_r.mask};
            default: mapped = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:10] != '0)
        begin
            mapped = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        q_nxt = q_r;
        wbyte = pwdata[7:0];
        access = psel && penable;
        // Write lands on the edge where pready is seen high
        wrEn = access && q_r.pready && pwrite && mapped;
        compMode = q_r.modeB[pwm_pkg::MODE_BIT];
        // Reaching or passing the limit ticks, so a smaller prescale
        // written mid-count cannot stall the counter until pre wraps
        tick = q_r.en && (q_r.pre >= preLimit(q_r.cks));
        wrap = tick && (q_r.cnt == q_r.actPrd);
        for (int i = 0; i < 3; i++)
        begin
            dutyReg[i] = {q_r.dutyHigh[i], q_r.lowBits[2*i +: 2]};
            raw[i] = q_r.en && (q_r.cnt < q_r.actDuty[i]);
            // Secondary is the primary's complement; channel 4/5 duty
            // storage plays no part here
            raw[i+3] = compMode && q_r.en && !raw[i];
            dly[i] = q_r.deadCfg[pwm_pkg::PDR_LSB +: 4];
            dly[i+3] = q_r.deadCfg[pwm_pkg::PDF_LSB +: 4];
        end

        // One-wait-state slave: one extra access cycle to register data
        q_nxt.pready = access && !q_r.pready;
        if (access && !q_r.pready)
        begin
            q_nxt.pslverr = !mapped;
            q_nxt.prdata = pwrite ? 32'h00000000 : {pwm_pkg::PAD_ZERO, rbyte};
        end
        else
        begin
            q_nxt.pslverr = 1'b0;
        end

        if (wrEn)
        begin
            case (idx)
                pwm_pkg::IDX_CFG:
                begin
                    q_nxt.cks = wbyte[pwm_pkg::CKS_LSB +: 2];
                    q_nxt.inv = wbyte[5:0];
                end
                pwm_pkg::IDX_CTRL: q_nxt.en = wbyte[pwm_pkg::EN_BIT];
                pwm_pkg::IDX_PRD: q_nxt.prdHigh = wbyte;
                pwm_pkg::IDX_LOW: q_nxt.lowBits = wbyte;
                pwm_pkg::IDX_DTY0: q_nxt.dutyHigh[0] = wbyte;
                pwm_pkg::IDX_DTY1: q_nxt.dutyHigh[1] = wbyte;
                pwm_pkg::IDX_DTY2: q_nxt.dutyHigh[2] = wbyte;
                pwm_pkg::IDX_MODEB: q_nxt.modeB = wbyte & pwm_pkg::MODEB_MASK;
                pwm_pkg::IDX_DEAD: q_nxt.deadCfg = wbyte;
                pwm_pkg::IDX_CH4: q_nxt.ch4Duty = wbyte;
                pwm_pkg::IDX_CH5: q_nxt.ch5Duty = wbyte;
                pwm_pkg::IDX_IMASK: q_nxt.mask = wbyte[0];
                default: q_nxt.mask = q_r.mask;
            endcase
        end

        // Counter, prescaler and period-boundary reload
        if (!q_r.en)
        begin
            q_nxt.pre = '0;
            q_nxt.cnt = '0;
        end
        else if (tick)
        begin
            q_nxt.pre = '0;
            q_nxt.cnt = wrap ? '0 : q_r.cnt + pwm_pkg::CNT_ONE;
        end
        else
        begin
            q_nxt.pre = q_r.pre + pwm_pkg::PRE_ONE;
        end
        // Shadows follow software while stopped, so a start uses fresh values
        if (!q_r.en || wrap)
        begin
            q_nxt.actDuty = dutyReg;
            q_nxt.actPrd = {q_r.prdHigh, q_r.lowBits[pwm_pkg::PRDLO_LSB +: 2]};
        end

        // Set beats a same-cycle write-one-to-clear
        if (wrap)
        begin
            q_nxt.flag = 1'b1;
        end
        else if (wrEn && idx == pwm_pkg::IDX_ISTAT && wbyte[0])
        begin
            q_nxt.flag = 1'b0;
        end
        q_nxt.irq = q_r.flag && q_r.mask;

        // Dead time: only rising edges are delayed, falls are immediate,
        // so complementary raw levels can never overlap at the output
        for (int i = 0; i < 6; i++)
        begin
            q_nxt.o[i] = raw[i] && (q_r.dc[i] >= dly[i]);
            if (!raw[i])
            begin
                q_nxt.dc[i] = '0;
            end
            else if (q_r.dc[i] < dly[i])
            begin
                q_nxt.dc[i] = q_r.dc[i] + pwm_pkg::DT_ONE;
            end
        end
        q_nxt.out = q_r.o ^ q_r.inv;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q_r <= '0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_noOverlap;
        !(q_r.o[0] && q_r.o[3]) && !(q_r.o[1] && q_r.o[4])
            && !(q_r.o[2] && q_r.o[5]);
    endproperty
    a_noOverlap: assert property (p_noOverlap)
        else $error("pair outputs active together");

    property p_wrap;
        wrap |=> (q_r.cnt == '0) && q_r.flag;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap at period");

    property p_flagIrq;
        (q_r.flag && q_r.mask) |=> irq;
    endproperty
    a_flagIrq: assert property (p_flagIrq)
        else $error("interrupt missing for masked-in flag");

    property p_disable;
        !q_r.en |=> (q_r.cnt == '0) && (q_r.o == '0);
    endproperty
    a_disable: assert property (p_disable)
        else $error("disabled unit kept counting or driving");

    property p_dutyHold;
        (q_r.en && !wrap) |=> $stable(q_r.actDuty);
    endproperty
    a_dutyHold: assert property (p_dutyHold)
        else $error("duty changed inside a period");

    property p_prdHold;
        (q_r.en && !wrap) |=> $stable(q_r.actPrd);
    endproperty
    a_prdHold: assert property (p_prdHold)
        else $error("period changed inside a period");

    property p_invert;
        ##1 (pwmOut == ($past(q_r.o) ^ $past(q_r.inv)));
    endproperty
    a_invert: assert property (p_invert)
        else $error("output polarity wrong");

    property p_zeroDead;
        ($rose(raw[0]) && dly[0] == '0) |=> q_r.o[0]
            ##1 pwmOut[0] != q_r.inv[0];
    endproperty
    a_zeroDead: assert property (p_zeroDead)
        else $error("zero dead time delayed primary");

    property p_secDead;
        ($rose(raw[3]) && dly[3] == 4'h2) |=> !q_r.o[3] ##1 !q_r.o[3]
            ##1 (q_r.o[3] || !$past(raw[3]) || !$past(raw[3], 2));
    endproperty
    a_secDead: assert property (p_secDead)
        else $error("falling dead time wrong");

    property p_primDead;
        ($rose(raw[0]) && dly[0] == 4'h1) |=> !q_r.o[0]
            ##1 (q_r.o[0] || !$past(raw[0]));
    endproperty
    a_primDead: assert property (p_primDead)
        else $error("rising dead time wrong");

    property p_fastClock;
        (q_r.en && q_r.cks == 2'h0) |-> tick;
    endproperty
    a_fastClock: assert property (p_fastClock)
        else $error("undivided clock not ticking");

    property p_complement;
        (compMode && q_r.en) |-> (raw[3] == !raw[0]);
    endproperty
    a_complement: assert property (p_complement)
        else $error("secondary not complement of primary");
endmodule : complementary_pwm_dead_time
`default_nettype wire

// >>> bench/gate_drive_model.sv
`default_nettype none
module gate_drive_model
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [5:0] pwmOut,
    output logic overlap
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sticky so a single-cycle shoot-through is never missed
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            overlap <= 1'b0;
        else if (|(pwmOut[2:0] & pwmOut[5:3]))
            overlap <= 1'b1;
    end
endmodule : gate_drive_model
`default_nettype wire

// >>> bench/complementary_pwm_dead_time_tb_top.sv
`default_nettype none
module complementary_pwm_dead_time_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, overlap;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [5:0] pwmOut;
    int failures = 0;
    int checked = 0;
    logic [31:0] c;
    int sh[4] = '{0, 1, 3, 5};
    complementary_pwm_dead_time #(.ADDR_W(12)) i_dut (.clk(clk),
        .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pwmOut(pwmOut), .irq(irq));
    gate_drive_model i_drv (.clk(clk), .rstn(rstn), .pwmOut(pwmOut),
        .overlap(overlap));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compares=%0d mismatches=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Request held until pready is sampled high; one idle edge after
    task automatic apb(input logic w, input logic [7:0] idx,
        input logic [7:0] wd, output logic [31:0] rd, output logic err);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            failures++;
            close_out();
        end
        else
        begin
            @(posedge clk);
        end
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask : wr
    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp,
        input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        chk(r, {24'h000000, exp});
        chk({31'h0, e}, {31'h0, experr});
    endtask : rchk
    // Window is a whole number of periods, so phase does not matter
    task automatic meas(input int ch, input int n, output logic [31:0] cnt);
        cnt = 32'h00000000;
        repeat (300) @(posedge clk);
        repeat (n)
        begin
            @(posedge clk);
            // An unknown pin level makes the whole count unknown
            cnt = cnt + {31'h0, pwmOut[ch]};
        end
    endtask : meas
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_reset();
        rchk(pwm_pkg::IDX_DTY0, 8'h00, 1'b0);
        rchk(pwm_pkg::IDX_DEAD, 8'h00, 1'b0);
        rchk(8'h10, 8'h00, 1'b1);
        chk({26'h0, pwmOut}, 32'h0);
    endtask : sc_reset
    task automatic sc_wave();
        wr(pwm_pkg::IDX_LOW, 8'hC2);
        wr(pwm_pkg::IDX_DTY0, 8'h00);
        wr(pwm_pkg::IDX_PRD, 8'h00);
        wr(pwm_pkg::IDX_MODEB, 8'h80);
        wr(pwm_pkg::IDX_CTRL, 8'h80);
        rchk(pwm_pkg::IDX_LOW, 8'hC2, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            wr(pwm_pkg::IDX_CFG, 8'(i << 6));
            meas(0, 40 << sh[i], c);
            chk(c, 20 << sh[i]);
        end
        wr(pwm_pkg::IDX_CFG, 8'h00);
        meas(3, 40, c);
        chk(c, 20);
        wr(pwm_pkg::IDX_LOW, 8'hC1);
        wr(pwm_pkg::IDX_CH4, 8'hFF);
        wr(pwm_pkg::IDX_CH5, 8'hFF);
        meas(0, 40, c);
        chk(c, 10);
        wr(pwm_pkg::IDX_LOW, 8'hC5);
        meas(4, 40, c);
        chk(c, 30);
        wr(pwm_pkg::IDX_LOW, 8'hC2);
        wr(pwm_pkg::IDX_PRD, 8'h01);
        meas(0, 80, c);
        chk(c, 20);
        wr(pwm_pkg::IDX_DEAD, 8'h21);
        meas(0, 80, c);
        chk(c, 10);
        meas(3, 80, c);
        chk(c, 40);
        chk({31'h0, overlap}, 32'h0);
    endtask : sc_wave
    task automatic sc_irq();
        wr(pwm_pkg::IDX_IMASK, 8'h01);
        repeat (20) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rchk(pwm_pkg::IDX_ISTAT, 8'h01, 1'b0);
        wr(pwm_pkg::IDX_IMASK, 8'h00);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(pwm_pkg::IDX_CTRL, 8'h00);
        wr(pwm_pkg::IDX_ISTAT, 8'h01);
        rchk(pwm_pkg::IDX_ISTAT, 8'h00, 1'b0);
        wr(pwm_pkg::IDX_IMASK, 8'h01);
        repeat (20) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        chk({26'h0, pwmOut}, 32'h0);
    endtask : sc_irq
    // Last, because the pin model reads inverted pins as overlap
    task automatic sc_invert();
        wr(pwm_pkg::IDX_LOW, 8'hC1);
        wr(pwm_pkg::IDX_PRD, 8'h00);
        wr(pwm_pkg::IDX_DEAD, 8'h00);
        wr(pwm_pkg::IDX_CFG, 8'h01);
        wr(pwm_pkg::IDX_CTRL, 8'h80);
        meas(0, 40, c);
        chk(c, 30);
    endtask : sc_invert
    // ------------------------------------------------------------
    // Clock, reset and sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        close_out();
    end
    initial
    begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        sc_reset();
        sc_wave();
        sc_irq();
        sc_invert();
        close_out();
    end
endmodule : complementary_pwm_dead_time_tb_top
`default_nettype wire
